// [rtl/opdec_map.svh]
// Constants for the opcode decoder and state-timing sequencer
// Function
// RL1 - Class chosen from instruction bits 15..8
// RL2 - Bit 7 splits pairs sharing first byte
// RL3 - Check bits below 7 before calling move
// RL4 - Branch aliases share encodings, execute identically
// RL5 - States equal sum of counts times costs
// RL6 - External byte 3+m, other access 6+2m
// RL7 - E-clock byte access takes 9 to 16
// RL8 - Bit-set absolute: two fetch, two byte
// RL9 - Indirect call: two fetch, one branch, one stack
// RL10 - Cycles issued in turn, next after total
`ifndef OPDEC_MAP_SVH
`define OPDEC_MAP_SVH

// ----------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------
`define OPD_FB_HI       15
`define OPD_FB_LO       8
`define OPD_PAIR_BIT    7
`define OPD_DIR_BIT     6
`define OPD_BRANCH_HI   4'h4
`define OPD_OP_MOVABS   8'h6a
`define OPD_OP_BLKMOV   8'h7b
`define OPD_BLK_LOW7    7'h5c
`define OPD_OP_CALLIND  8'h5f
`define OPD_OP_BITABS   8'h7f
`define OPD_SUB_BIT_SET_INSTR    8'h70
`define OPD_SUB_BNOT    8'h71
`define OPD_SUB_BCLR    8'h72

// ----------------------------------------------------------------
// State costs per cycle
// ----------------------------------------------------------------
`define OPD_S_ONCHIP    5'h02
`define OPD_S_REG_BYTE  5'h03
`define OPD_S_REG_WIDE  5'h06
`define OPD_S_INTERNAL  5'h02
`define OPD_S_ECLK_MIN  5'h09
`define OPD_ECLK_DIV    3'h7
`define OPD_CLK_NS      10
`define OPD_BLK_INTERN  2'h2

`endif

// [rtl/opdec_pkg.sv]
// Types shared by the opcode decoder and its cost lookup
package opdec_pkg;

  typedef enum logic [2:0] {
    OPD_K_FETCH, OPD_K_BRADDR, OPD_K_STACK, OPD_K_BYTE, OPD_K_WORD, OPD_K_INTERNAL
  } opdec_kind_e;

  typedef enum logic [1:0] {OPD_L_ONCHIP, OPD_L_REGFIELD, OPD_L_EXTERNAL} opdec_loc_e;

  typedef enum logic [3:0] {
    OPD_C_OTHER, OPD_C_BRANCH, OPD_C_MOVE, OPD_C_BLOCK, OPD_C_ECLK_FROM,
    OPD_C_ECLK_TO, OPD_C_BIT_SET, OPD_C_BIT_RMW, OPD_C_BIT_READ, OPD_C_CALL_IND
  } opdec_class_e;

  typedef enum logic [1:0] {OPD_ST_IDLE, OPD_ST_RUN, OPD_ST_WAIT} opdec_state_e;

  typedef logic [5:0][1:0] opdec_counts_t;

  // Where each kind of cycle goes, plus the wait-state count
  typedef struct packed {
    opdec_loc_e fetch_loc;
    opdec_loc_e data_loc;
    opdec_loc_e stack_loc;
    logic [2:0] wait_cnt;
  } opdec_env_s;

  typedef struct packed {
    opdec_state_e st;
    logic [2:0]   eclk_phase;
    opdec_counts_t cnt;
    logic [4:0]   left;
    logic [7:0]   total;
    opdec_env_s   env;
    logic         ready;
    logic         cyc_valid;
    opdec_kind_e  kind;
    logic [4:0]   cyc_states;
    logic         done;
    logic [7:0]   total_out;
    opdec_class_e cls;
    logic [3:0]   cond;
  } opdec_st_s;

endpackage : opdec_pkg

// [rtl/opdec_cost.sv]
// State cost of one bus or internal cycle
`include "opdec_map.svh"
module opdec_cost (
  input  wire opdec_pkg::opdec_kind_e kind,      // Cycle kind
  input  wire opdec_pkg::opdec_loc_e  loc,       // Access location
  input  wire logic [2:0]             wait_cnt,  // Inserted wait states m
  input  wire logic                   eclk_sync, // Byte access tied to E clock
  input  wire logic [2:0]             eclk_phase,// Current E-clock phase
  output logic [4:0]                  states     // States for this cycle
);
  logic [4:0] m5;

  always_comb begin
    m5 = {2'b00, wait_cnt};
    states = `OPD_S_ONCHIP;
    if (kind == opdec_pkg::OPD_K_INTERNAL) begin
      states = `OPD_S_INTERNAL;
    end else if (kind == opdec_pkg::OPD_K_BYTE) begin
      if (loc == opdec_pkg::OPD_L_EXTERNAL && eclk_sync) begin
        // Wait for the next E-clock edge, so 9 to 16 states
        states = `OPD_S_ECLK_MIN + {2'b00, `OPD_ECLK_DIV - eclk_phase}; // RL7
      end else if (loc == opdec_pkg::OPD_L_EXTERNAL) begin
        states = `OPD_S_REG_BYTE + m5; // RL6
      end else if (loc == opdec_pkg::OPD_L_REGFIELD) begin
        states = `OPD_S_REG_BYTE;
      end
    end else if (loc == opdec_pkg::OPD_L_EXTERNAL) begin
      states = `OPD_S_REG_WIDE + {m5[3:0], 1'b0}; // RL6
    end else if (loc == opdec_pkg::OPD_L_REGFIELD) begin
      states = `OPD_S_REG_WIDE;
    end
  end

endmodule : opdec_cost

// [rtl/opdec_core.sv]
// Opcode decoder and execution-state sequencer
`include "opdec_map.svh"
module opdec_core (
  input  wire logic                      clk,          // System clock
  input  wire logic                      sys_rst,      // Synchronous reset, high
  input  wire logic                      req_valid,    // Instruction offered
  input  wire logic [15:0]               instr_word,   // First instruction word
  input  wire logic [15:0]               instr_ext,    // Second instruction word
  input  wire opdec_pkg::opdec_env_s     env_in,       // Locations and wait states
  output logic                           req_ready,    // Idle, can take an instruction
  output opdec_pkg::opdec_class_e        dec_class,    // Decoded class
  output logic [3:0]                     branch_cond,  // Branch condition code
  output logic                           cyc_valid,    // Start of one cycle, pulse
  output opdec_pkg::opdec_kind_e         cyc_kind,     // Kind of that cycle
  output logic [4:0]                     cyc_states,   // States charged to it
  output logic                           done,         // Instruction finished, pulse
  output logic [7:0]                     total_states  // States of finished instruction
);

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic opdec_pkg::opdec_class_e decode_class(input logic [15:0] w,
                                                           input logic [15:0] x);
    logic [7:0] fb;
    fb = w[`OPD_FB_HI:`OPD_FB_LO]; // RL1
    decode_class = opdec_pkg::OPD_C_OTHER;
    if (fb[7:4] == `OPD_BRANCH_HI) begin
      decode_class = opdec_pkg::OPD_C_BRANCH; // RL4
    end else if (fb == `OPD_OP_MOVABS) begin
      if (w[`OPD_DIR_BIT]) begin
        decode_class = w[`OPD_PAIR_BIT] ? opdec_pkg::OPD_C_ECLK_TO // RL2
                                        : opdec_pkg::OPD_C_ECLK_FROM;
      end else begin
        decode_class = opdec_pkg::OPD_C_MOVE;
      end
    end else if (fb == `OPD_OP_BLKMOV) begin
      // Same as a move down to bit 7, the low bits tell them apart
      decode_class = (w[6:0] == `OPD_BLK_LOW7) ? opdec_pkg::OPD_C_BLOCK // RL3
                                               : opdec_pkg::OPD_C_MOVE;
    end else if (fb == `OPD_OP_CALLIND) begin
      decode_class = opdec_pkg::OPD_C_CALL_IND;
    end else if (fb == `OPD_OP_BITABS) begin
      if (x[15:8] == `OPD_SUB_BIT_SET_INSTR) begin
        decode_class = opdec_pkg::OPD_C_BIT_SET;
      end else if (x[15:8] == `OPD_SUB_BNOT || x[15:8] == `OPD_SUB_BCLR) begin
        decode_class = opdec_pkg::OPD_C_BIT_RMW;
      end else begin
        decode_class = opdec_pkg::OPD_C_BIT_READ;
      end
    end
  endfunction : decode_class

  // Order: fetch, branch address, stack, byte, word, internal
  function automatic opdec_pkg::opdec_counts_t class_counts(input opdec_pkg::opdec_class_e c);
    class_counts = '0;
    class_counts[0] = 2'h1;
    unique case (c)
      opdec_pkg::OPD_C_BRANCH:    class_counts[0] = 2'h2;
      opdec_pkg::OPD_C_MOVE,
      opdec_pkg::OPD_C_ECLK_FROM,
      opdec_pkg::OPD_C_ECLK_TO,
      opdec_pkg::OPD_C_BIT_READ: begin
        class_counts[0] = 2'h2;
        class_counts[3] = 2'h1;
      end
      opdec_pkg::OPD_C_BIT_SET,
      opdec_pkg::OPD_C_BIT_RMW: begin
        class_counts[0] = 2'h2; // RL8
        class_counts[3] = 2'h2; // RL8
      end
      opdec_pkg::OPD_C_CALL_IND: begin
        class_counts[0] = 2'h2; // RL9
        class_counts[1] = 2'h1; // RL9
        class_counts[2] = 2'h1; // RL9
      end
      opdec_pkg::OPD_C_BLOCK: begin
        class_counts[0] = 2'h2;
        class_counts[5] = `OPD_BLK_INTERN;
      end
      opdec_pkg::OPD_C_OTHER:     class_counts[0] = 2'h1;
    endcase
  endfunction : class_counts

  // ----------------------------------------------------------------
  // State and next-state
  // ----------------------------------------------------------------
  opdec_pkg::opdec_st_s  s_reg;
  opdec_pkg::opdec_st_s  s_next;
  opdec_pkg::opdec_kind_e pick_kind;
  opdec_pkg::opdec_loc_e pick_loc;
  logic                  pick_any;
  logic [4:0]            pick_cost;
  logic                  eclk_cls;

  always_comb begin
    pick_any  = 1'b0;
    pick_kind = opdec_pkg::OPD_K_FETCH;
    for (int i = 5; i >= 0; i--) begin
      if (s_reg.cnt[i] != 2'h0) begin
        pick_any  = 1'b1;
        pick_kind = opdec_pkg::opdec_kind_e'(3'(i));
      end
    end
    unique case (pick_kind)
      opdec_pkg::OPD_K_FETCH: pick_loc = s_reg.env.fetch_loc;
      opdec_pkg::OPD_K_STACK: pick_loc = s_reg.env.stack_loc;
      default:                pick_loc = s_reg.env.data_loc;
    endcase
  end

  assign eclk_cls = (s_reg.cls == opdec_pkg::OPD_C_ECLK_FROM) ||
                    (s_reg.cls == opdec_pkg::OPD_C_ECLK_TO);

  opdec_cost u_cost (
    .kind       (pick_kind),
    .loc        (pick_loc),
    .wait_cnt   (s_reg.env.wait_cnt),
    .eclk_sync  (eclk_cls),
    .eclk_phase (s_reg.eclk_phase),
    .states     (pick_cost)
  );

  always_comb begin
    s_next            = s_reg;
    s_next.eclk_phase = s_reg.eclk_phase + 3'h1;
    s_next.cyc_valid  = 1'b0;
    s_next.done       = 1'b0;
    unique case (s_reg.st)
      opdec_pkg::OPD_ST_IDLE: begin
        if (req_valid) begin
          s_next.cls   = decode_class(instr_word, instr_ext);
          s_next.cond  = instr_word[11:8]; // RL4
          s_next.cnt   = class_counts(decode_class(instr_word, instr_ext));
          s_next.env   = env_in;
          s_next.total = 8'h00;
          s_next.ready = 1'b0;
          s_next.st    = opdec_pkg::OPD_ST_RUN;
        end
      end
      opdec_pkg::OPD_ST_RUN: begin
        if (pick_any) begin
          // This clock is the cycle's first state
          s_next.cnt[pick_kind] = s_reg.cnt[pick_kind] - 2'h1; // RL10
          s_next.kind       = pick_kind;
          s_next.cyc_states = pick_cost;
          s_next.cyc_valid  = 1'b1;
          s_next.left       = pick_cost - 5'h1;
          s_next.total      = s_reg.total + {3'h0, pick_cost}; // RL5
          s_next.st         = opdec_pkg::OPD_ST_WAIT;
        end else begin
          s_next.done      = 1'b1;
          s_next.total_out = s_reg.total; // RL5
          s_next.ready     = 1'b1;
          s_next.st        = opdec_pkg::OPD_ST_IDLE;
        end
      end
      opdec_pkg::OPD_ST_WAIT: begin
        s_next.left = s_reg.left - 5'h1;
        if (s_reg.left == 5'h1) begin
          s_next.st = opdec_pkg::OPD_ST_RUN; // RL10
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg       <= '0;
      s_reg.st    <= opdec_pkg::OPD_ST_IDLE;
      s_reg.ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign req_ready    = s_reg.ready;
  assign dec_class    = s_reg.cls;
  assign branch_cond  = s_reg.cond;
  assign cyc_valid    = s_reg.cyc_valid;
  assign cyc_kind     = s_reg.kind;
  assign cyc_states   = s_reg.cyc_states;
  assign done         = s_reg.done;
  assign total_states = s_reg.total_out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] chk_sum;
  logic [4:0] chk_gap;
  logic [4:0] chk_last;
  logic       chk_seen;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chk_sum  <= 8'h00;
      chk_gap  <= 5'h00;
      chk_last <= 5'h00;
      chk_seen <= 1'b0;
    end else begin
      chk_gap <= chk_gap + 5'h1;
      if (req_valid && req_ready) begin
        chk_sum <= 8'h00;
      end
      if (cyc_valid) begin
        chk_sum  <= chk_sum + {3'h0, cyc_states};
        chk_gap  <= 5'h01;
        chk_last <= cyc_states;
        chk_seen <= 1'b1;
      end
      if (done) begin
        chk_seen <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence seq_take(logic [7:0] op);
    req_valid && req_ready && instr_word[15:8] == op;
  endsequence

  sequence seq_take_hi(logic [3:0] hi);
    req_valid && req_ready && instr_word[15:12] == hi;
  endsequence

  AST_BRANCH_ALIAS: assert property (seq_take_hi(`OPD_BRANCH_HI) |=> // RL4
    dec_class == opdec_pkg::OPD_C_BRANCH && branch_cond == $past(instr_word[11:8]))
    else $error("branch encoding not decoded to shared class");

  AST_PAIR_BIT7: assert property (seq_take(`OPD_OP_MOVABS) ##0 instr_word[6] |=> // RL2
    dec_class == ($past(instr_word[7]) ? opdec_pkg::OPD_C_ECLK_TO
                                       : opdec_pkg::OPD_C_ECLK_FROM))
    else $error("bit 7 did not split the pair");

  AST_BLOCK_LOW: assert property (seq_take(`OPD_OP_BLKMOV) |=> // RL3
    (dec_class == opdec_pkg::OPD_C_BLOCK) == ($past(instr_word[6:0]) == `OPD_BLK_LOW7))
    else $error("block transfer not told from move");

  AST_BIT_SET_INSTR_COUNTS: assert property (seq_take(`OPD_OP_BITABS) ##0 // RL8
    instr_ext[15:8] == `OPD_SUB_BIT_SET_INSTR |=> s_reg.cnt == 12'h082)
    else $error("bit-set cycle counts wrong");

  AST_CALL_COUNTS: assert property (seq_take(`OPD_OP_CALLIND) |=> // RL9
    s_reg.cnt == 12'h016)
    else $error("indirect call cycle counts wrong");

  AST_TOTAL_SUM: assert property (done |-> total_states == chk_sum) // RL5
    else $error("total states differ from cycle sum");

  AST_EXT_COST: assert property (cyc_valid && !eclk_cls && // RL6
    s_reg.env.data_loc == opdec_pkg::OPD_L_EXTERNAL &&
    (cyc_kind == opdec_pkg::OPD_K_BYTE || cyc_kind == opdec_pkg::OPD_K_WORD) |->
    cyc_states == ((cyc_kind == opdec_pkg::OPD_K_BYTE) ? 5'(3 + s_reg.env.wait_cnt)
                                                       : 5'(6 + 2 * s_reg.env.wait_cnt)))
    else $error("external access cost wrong");

  AST_ECLK_RANGE: assert property (cyc_valid && eclk_cls && // RL7
    cyc_kind == opdec_pkg::OPD_K_BYTE && s_reg.env.data_loc == opdec_pkg::OPD_L_EXTERNAL |->
    cyc_states >= 5'h09 && cyc_states <= 5'h10)
    else $error("E-clock byte access outside 9 to 16");

  AST_CYCLE_SPACING: assert property ((cyc_valid || done) && chk_seen |-> // RL10
    chk_gap == chk_last)
    else $error("next cycle started before states elapsed");

endmodule : opdec_core

// [bench/testbench.sv]
// Self-checking bench for the opcode decoder and state sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Expected-result records
  // ----------------------------------------------------------------
  typedef struct packed {
    opdec_pkg::opdec_kind_e kind;
    logic [4:0]             st;
    logic                   rng;
  } opdec_tb_cyc_s;
  typedef struct packed {
    opdec_pkg::opdec_class_e cls;
    logic [3:0]              cond;
    logic [7:0]              tot;
    logic                    rng;
  } opdec_tb_done_s;

  logic                    clk = 1'b0;
  logic                    sys_rst;
  logic                    req_valid;
  logic [15:0]             instr_word;
  logic [15:0]             instr_ext;
  opdec_pkg::opdec_env_s   env_in;
  logic                    req_ready;
  opdec_pkg::opdec_class_e dec_class;
  logic [3:0]              branch_cond;
  logic                    cyc_valid;
  opdec_pkg::opdec_kind_e  cyc_kind;
  logic [4:0]              cyc_states;
  logic                    done;
  logic [7:0]              total_states;
  int                      failures = 0;
  int                      n_checks = 0;
  int                      n_cyc = 0;
  int                      gap = 0;
  int                      want = 0;
  opdec_tb_cyc_s           cyc_q [$];
  opdec_tb_done_s          done_q [$];
  opdec_tb_cyc_s           mc;
  opdec_tb_done_s          md;
  logic [15:0]             rw;
  logic [15:0]             re;
  logic [15:0] w_tab [12] = '{16'h6a00, 16'h6a80, 16'h6a40, 16'h6ac0, 16'h7b5c, 16'h7bdc,
                              16'h7b1d, 16'h5f30, 16'h7f00, 16'h7f00, 16'h7f00, 16'h7f00};
  logic [15:0] e_tab [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                              16'h0000, 16'h0000, 16'h7000, 16'h7100, 16'h7200, 16'h7300};

  opdec_core uut (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .req_valid    (req_valid),
    .instr_word   (instr_word),
    .instr_ext    (instr_ext),
    .env_in       (env_in),
    .req_ready    (req_ready),
    .dec_class    (dec_class),
    .branch_cond  (branch_cond),
    .cyc_valid    (cyc_valid),
    .cyc_kind     (cyc_kind),
    .cyc_states   (cyc_states),
    .done         (done),
    .total_states (total_states)
  );

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  function automatic opdec_pkg::opdec_env_s env3(input int f, input int d, input int s,
                                                 input int m);
    env3.fetch_loc = opdec_pkg::opdec_loc_e'(f);
    env3.data_loc  = opdec_pkg::opdec_loc_e'(d);
    env3.stack_loc = opdec_pkg::opdec_loc_e'(s);
    env3.wait_cnt  = 3'(m);
  endfunction : env3

  function automatic logic [4:0] cost(input int k, input opdec_pkg::opdec_loc_e l,
                                      input logic [2:0] m);
    if (k == 5 || l == opdec_pkg::OPD_L_ONCHIP) return 5'h02;
    if (l == opdec_pkg::OPD_L_REGFIELD) return (k == 3) ? 5'h03 : 5'h06;
    return (k == 3) ? 5'h03 + m : 5'h06 + {m, 1'b0};
  endfunction : cost

  // Expected cycles in kind order, then the finishing record
  task automatic model(input logic [15:0] w, input logic [15:0] e,
                       input opdec_pkg::opdec_env_s v);
    int n [6];
    opdec_tb_cyc_s c;
    opdec_tb_done_s d;
    opdec_pkg::opdec_loc_e l;
    n = '{2, 0, 0, 0, 0, 0};
    d = '0;
    d.cond = w[11:8];
    d.cls = opdec_pkg::OPD_C_OTHER;
    if (w[15:12] == 4'h4) begin
      d.cls = opdec_pkg::OPD_C_BRANCH;
    end else if (w[15:8] == 8'h6a) begin
      d.cls = !w[6] ? opdec_pkg::OPD_C_MOVE :
              (w[7] ? opdec_pkg::OPD_C_ECLK_TO : opdec_pkg::OPD_C_ECLK_FROM);
      n[3] = 1;
    end else if (w[15:8] == 8'h7b) begin
      d.cls = (w[6:0] == 7'h5c) ? opdec_pkg::OPD_C_BLOCK : opdec_pkg::OPD_C_MOVE;
      if (w[6:0] == 7'h5c) n[5] = 2;
      else n[3] = 1;
    end else if (w[15:8] == 8'h5f) begin
      d.cls = opdec_pkg::OPD_C_CALL_IND;
      n[1] = 1;
      n[2] = 1;
    end else if (w[15:8] == 8'h7f) begin
      d.cls = (e[15:8] == 8'h70) ? opdec_pkg::OPD_C_BIT_SET :
              (e[15:8] == 8'h71 || e[15:8] == 8'h72) ? opdec_pkg::OPD_C_BIT_RMW :
              opdec_pkg::OPD_C_BIT_READ;
      n[3] = (d.cls == opdec_pkg::OPD_C_BIT_READ) ? 1 : 2;
    end else begin
      n[0] = 1;
    end
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < n[k]; j++) begin
        l = (k == 0) ? v.fetch_loc : (k == 2) ? v.stack_loc : v.data_loc;
        c.kind = opdec_pkg::opdec_kind_e'(k);
        c.st = cost(k, l, v.wait_cnt);
        c.rng = k == 3 && l == opdec_pkg::OPD_L_EXTERNAL && (d.cls == opdec_pkg::OPD_C_ECLK_TO
                || d.cls == opdec_pkg::OPD_C_ECLK_FROM);
        if (c.rng) d.rng = 1'b1;
        else d.tot = d.tot + 8'(c.st);
        cyc_q.push_back(c);
      end
    end
    done_q.push_back(d);
  endtask : model

  // One accepted request, then one cycle of a request that must be ignored
  task automatic issue(input logic [15:0] w, input logic [15:0] e,
                       input opdec_pkg::opdec_env_s v);
    int g;
    g = 0;
    while (req_ready !== 1'b1 && g < 200) begin
      @(negedge clk);
      g++;
    end
    check({15'h0, req_ready}, 16'h0001);
    model(w, e, v);
    req_valid  = 1'b1;
    instr_word = w;
    instr_ext  = e;
    env_in     = v;
    @(negedge clk);
    instr_word = 16'($urandom);
    instr_ext  = 16'($urandom);
    @(negedge clk);
    req_valid = 1'b0;
  endtask : issue

  // ----------------------------------------------------------------
  // Output monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      gap = 0;
      want = 0;
    end else begin
      gap = gap + 1;
      if (cyc_valid === 1'b1) begin
        check(16'(gap), 16'(want));
        if (cyc_q.size() == 0) begin
          check(16'h0001, 16'h0000);
        end else begin
          mc = cyc_q.pop_front();
          check({13'h0, cyc_kind}, {13'h0, mc.kind});
          if (mc.rng) begin
            check({15'h0, cyc_states >= 5'h09 && cyc_states <= 5'h10}, 16'h0001);
            want = cyc_states;
          end else begin
            check({11'h0, cyc_states}, {11'h0, mc.st});
            want = mc.st;
          end
        end
        gap = 0;
      end
      if (done === 1'b1) begin
        check(16'(gap), 16'(want));
        if (done_q.size() == 0) begin
          check(16'h0001, 16'h0000);
        end else begin
          md = done_q.pop_front();
          check({12'h0, dec_class}, {12'h0, md.cls});
          check({12'h0, branch_cond}, {12'h0, md.cond});
          check({15'h0, req_ready}, 16'h0001);
          if (md.rng) check({15'h0, total_states >= md.tot + 8'h09 &&
                                    total_states <= md.tot + 8'h10}, 16'h0001);
          else check({8'h0, total_states}, {8'h0, md.tot});
        end
      end
      if (req_valid === 1'b1 && req_ready === 1'b1) begin
        gap = 0;
        want = 2;
      end
    end
  end

  // Sized for a few hundred instructions of at most about a hundred cycles
  always @(posedge clk) begin
    n_cyc++;
    if (n_cyc > 40000) begin
      failures++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst    = 1'b1;
    req_valid  = 1'b0;
    instr_word = 16'h0000;
    instr_ext  = 16'h0000;
    env_in     = '0;
    void'($urandom(64385));
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    check({15'h0, req_ready}, 16'h0001);
    check({15'h0, cyc_valid | done}, 16'h0000);
    check({4'h0, dec_class, total_states}, 16'h0000);
    issue(16'h7f00, 16'h7000, env3(0, 0, 0, 0));
    issue(16'h7f00, 16'h7000, env3(2, 1, 2, 1));
    issue(16'h5f30, 16'h0000, env3(2, 2, 2, 1));
    // Aliases reuse codes 0, 1, 4 and 5, so every code is covered
    for (int i = 0; i < 16; i++) begin
      issue({4'h4, 4'(i), 8'($urandom)}, 16'($urandom),
            env3($urandom_range(2), $urandom_range(2), 0, $urandom_range(7)));
    end
    for (int i = 0; i < 12; i++) begin
      for (int dl = 0; dl < 3; dl++) begin
        issue(w_tab[i], e_tab[i], env3($urandom_range(2), dl, $urandom_range(2),
                                       $urandom_range(7)));
      end
    end
    repeat (150) begin
      rw = 16'($urandom);
      re = 16'($urandom);
      if ($urandom_range(1) == 1) rw[15:8] = w_tab[$urandom_range(11)][15:8];
      if ($urandom_range(1) == 1) re[15:8] = 8'h70 + 8'($urandom_range(3));
      issue(rw, re, env3($urandom_range(2), $urandom_range(2), $urandom_range(2),
                         $urandom_range(7)));
    end
    repeat (120) @(negedge clk);
    check(16'(cyc_q.size() + done_q.size()), 16'h0000);
    print_verdict();
  end

endmodule : testbench
